// file: rtl/sdp_pkg.sv
// Shared constants and types for the synthesizer divider program port
package sdp_pkg;

    // Field widths of the divider settings
    localparam int M_W = 9;                     // Feedback divide value width
    localparam int N_W = 3;                     // Output divider select width
    localparam int PROBE_W = 2;                 // Probe select width
    localparam int FRAME_W = PROBE_W + 2 * N_W + M_W; // Serial frame length
    localparam int HALF_W = 9;                  // Half-period counter width

    // One complete divider setting, in serial frame order (first bit shifted in on top)
    typedef struct packed {
        logic [PROBE_W-1:0] probe_sel;          // High bit then low bit
        logic [N_W-1:0] first_out_div_sel;      // Output A divider select
        logic [N_W-1:0] second_out_div_sel;     // Output B divider select
        logic [M_W-1:0] fb_div;                 // Feedback divide value
    } sdp_setting_t;

    // Probe source choices
    typedef enum logic [1:0] {
        PROBE_LOW = 2'h0,                       // Forced low
        PROBE_SHIFT = 2'h1,                     // Shift register serial output
        PROBE_FB = 2'h2,                        // Feedback divider output
        PROBE_OUT_A = 2'h3                      // Output A frequency
    } sdp_probe_t;

    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;   // Enables and divider clear
    localparam logic [7:0] STATUS_ADDR = 8'h04; // Active setting and mode
    localparam logic [7:0] SHIFT_ADDR = 8'h08;  // Raw shift register

    // Control register fields and reset value
    localparam int CTRL_OE_A_BIT = 0;           // Output A pair enable
    localparam int CTRL_OE_B_BIT = 1;           // Output B pair enable
    localparam int CTRL_OE_REF_BIT = 2;         // Reference copy enable
    localparam int CTRL_CLEAR_BIT = 3;          // Divider clear
    localparam int CTRL_W = 4;                  // Implemented control bits
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h3; // Pairs on, ref off, no clear

    // Status register fields
    localparam int STATUS_MODE_BIT = FRAME_W;   // Serial mode flag above setting

    // Output divider select to half-period lookup (even ratios keep 50% duty)
    function automatic logic [HALF_W-1:0] div_half(input logic [N_W-1:0] code);
        case (code)
            3'h0: div_half = 9'h001;            // Divide by 2
            3'h1: div_half = 9'h002;            // Divide by 4
            3'h2: div_half = 9'h003;            // Divide by 6
            3'h3: div_half = 9'h004;            // Divide by 8
            3'h4: div_half = 9'h005;            // Divide by 10
            3'h5: div_half = 9'h006;            // Divide by 12
            3'h6: div_half = 9'h008;            // Divide by 16
            default: div_half = 9'h00a;         // Divide by 20
        endcase
    endfunction : div_half

endpackage : sdp_pkg

// file: rtl/sdp_out_div.sv
// Fifty percent duty clock divider with synchronous clear
`timescale 1ns/100ps
`default_nettype none

module sdp_out_div #(
    parameter int HALF_W = 9                    // Half-period count width
) (
    input wire logic mclk,                      // Oscillator stand-in clock
    input wire logic rst,                       // Asynchronous reset, active high
    input wire logic clear,                     // Hold divider in reset
    input wire logic [HALF_W-1:0] half,         // Cycles per half period
    output logic div_out                        // Divided output
);

    logic [HALF_W-1:0] cnt_reg;                 // Cycles into current half

    ////////////////////////////////////////////////////////////////////////
    // Count half periods; clear parks output low and keeps the setting
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            div_out <= 1'b0;
        end else if (clear || half == '0) begin
            // Zero half would never toggle, so treat it as stopped
            cnt_reg <= '0;
            div_out <= 1'b0;
        end else if (cnt_reg >= half - 1'b1) begin
            // Using >= recovers at once when half shrinks mid-period
            cnt_reg <= '0;
            div_out <= ~div_out;                // Equal halves give 50% duty
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

endmodule : sdp_out_div
`default_nettype wire

// file: rtl/sdp_program_port.sv
// Divider program port: pin latch, serial loader, probe, enables, APB control
`timescale 1ns/100ps
`default_nettype none

module sdp_program_port #(
    parameter int ADDR_W = 8                    // APB address width
) (
    input wire logic mclk,                      // System clock, 100 MHz
    input wire logic rst,                       // Asynchronous reset, active high
    input wire logic psel,                      // APB select
    input wire logic penable,                   // APB access phase
    input wire logic pwrite,                    // APB write direction
    input wire logic [ADDR_W-1:0] paddr,        // APB byte address
    input wire logic [31:0] pwdata,             // APB write data
    output logic [31:0] prdata,                 // APB read data
    output logic pready,                        // APB ready
    output logic pslverr,                       // APB error on unmapped address
    input wire logic parallel_latch_strobe_n,   // Parallel load strobe pin
    input wire logic [sdp_pkg::M_W-1:0] fb_div_pins, // Feedback divider pins
    input wire logic [sdp_pkg::N_W-1:0] first_out_div_sel, // Output A select pins
    input wire logic [sdp_pkg::N_W-1:0] second_out_div_sel, // Output B select pins
    input wire logic serial_clk,                // Serial clock pin
    input wire logic serial_data,               // Serial data pin
    input wire logic serial_load,               // Serial load strobe pin
    input wire logic ref_in,                    // Reference oscillator level
    output logic first_pair_true,               // Output A true side
    output logic first_pair_comp,               // Output A complement side
    output logic second_pair_true,              // Output B true side
    output logic second_pair_comp,              // Output B complement side
    output logic probe_out,                     // Test probe output
    output logic ref_out,                       // Reference copy output
    output logic ref_out_oe                     // Reference copy drive enable
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    localparam int PIN_W = sdp_pkg::M_W + 2 * sdp_pkg::N_W + 5; // Synced pin count
    localparam int P_PLS = 0;                   // Parallel strobe position
    localparam int P_SCLK = 1;                  // Serial clock position
    localparam int P_SDAT = 2;                  // Serial data position
    localparam int P_SLD = 3;                   // Serial load position
    localparam int P_REF = 4;                   // Reference level position

    logic [PIN_W-1:0] pins_raw;                 // All asynchronous pins
    logic [PIN_W-1:0] sync_a_reg;               // First stage, read by second only
    logic [PIN_W-1:0] sync_b_reg;               // Second stage, safe to use
    logic [1:0] prev_reg;                       // Last serial load and clock levels

    assign pins_raw = {first_out_div_sel, second_out_div_sel, fb_div_pins,
                       ref_in, serial_load, serial_data, serial_clk,
                       parallel_latch_strobe_n};

    // Two flops on every pin; straps ride along since they are quasi-static
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_a_reg <= '0;
            sync_b_reg <= '0;
        end else begin
            sync_a_reg <= pins_raw;
            sync_b_reg <= sync_a_reg;
        end
    end

    // Edge history for serial load and serial clock
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= {sync_b_reg[P_SLD], sync_b_reg[P_SCLK]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded pin events
    logic pls_n;                                // Parallel strobe level
    logic sload;                                // Serial load level
    logic sclk_rise;                            // Serial clock rising edge
    logic sload_rise;                           // Serial load rising edge
    sdp_pkg::sdp_setting_t pin_setting;         // Setting presented on pins

    assign pls_n = sync_b_reg[P_PLS];
    assign sload = sync_b_reg[P_SLD];
    assign sclk_rise = sync_b_reg[P_SCLK] & ~prev_reg[0];
    assign sload_rise = sload & ~prev_reg[1];

    // Probe bits have no pins; they keep the active value
    assign pin_setting.probe_sel = '0;
    assign pin_setting.first_out_div_sel = sync_b_reg[PIN_W-1 -: sdp_pkg::N_W];
    assign pin_setting.second_out_div_sel =
        sync_b_reg[PIN_W-1-sdp_pkg::N_W -: sdp_pkg::N_W];
    assign pin_setting.fb_div = sync_b_reg[5 +: sdp_pkg::M_W];

    ////////////////////////////////////////////////////////////////////////
    // Serial shift register
    logic [sdp_pkg::FRAME_W-1:0] shift_reg;     // Serial frame being built
    logic [sdp_pkg::FRAME_W-1:0] shift_next;    // Frame after this clock
    logic serial_mode;                          // Strobe high, serial allowed

    assign serial_mode = pls_n;
    // First bit in ends on top: probe, A select, B select, feedback
    assign shift_next = {shift_reg[sdp_pkg::FRAME_W-2:0], sync_b_reg[P_SDAT]};

    // Shift only in serial mode on a serial clock rise
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shift_reg <= '0;
        end else if (serial_mode && sclk_rise) begin
            shift_reg <= shift_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active divider setting
    sdp_pkg::sdp_setting_t active_reg;          // Setting the dividers use
    logic mode_serial_reg;                      // Last load came from serial
    logic serial_transp;                        // Load high with a shift edge

    assign serial_transp = serial_mode && sload && sclk_rise && !sload_rise;

    // Pins pass through while strobe low; serial events override when high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            active_reg <= '0;
            mode_serial_reg <= 1'b0;
        end else if (!pls_n) begin
            // Transparent to the pins, so straps set the power-up value
            active_reg.first_out_div_sel <= pin_setting.first_out_div_sel;
            active_reg.second_out_div_sel <= pin_setting.second_out_div_sel;
            active_reg.fb_div <= pin_setting.fb_div;
            mode_serial_reg <= 1'b0;
        end else if (sload_rise) begin
            // Whole frame, probe bits included, moves at once
            active_reg <= shift_reg;
            mode_serial_reg <= 1'b1;
        end else if (serial_transp) begin
            // Load held high: each new bit lands in the dividers
            active_reg <= shift_next;
            mode_serial_reg <= 1'b1;
        end
        // Strobe rise and serial load fall simply stop updates
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register
    logic [sdp_pkg::CTRL_W-1:0] ctrl_reg;       // Enables and divider clear
    logic wr_en;                                // Write takes effect this edge
    logic setup;                                // APB setup cycle
    logic addr_ok;                              // Address is mapped

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && paddr == sdp_pkg::CTRL_ADDR;
    assign addr_ok = paddr == sdp_pkg::CTRL_ADDR || paddr == sdp_pkg::STATUS_ADDR
                     || paddr == sdp_pkg::SHIFT_ADDR;

    // Software writes enables and clear; reset matches pin pull defaults
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= sdp_pkg::CTRL_RESET;
        end else if (wr_en) begin
            ctrl_reg <= pwdata[sdp_pkg::CTRL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read path, zero wait states
    logic [31:0] rd_mux;                        // Data for the addressed register

    // Mux the three registers; unused bits read zero
    always_comb begin
        rd_mux = '0;
        case (paddr)
            sdp_pkg::CTRL_ADDR: begin
                rd_mux[sdp_pkg::CTRL_W-1:0] = ctrl_reg;
            end
            sdp_pkg::STATUS_ADDR: begin
                rd_mux[sdp_pkg::FRAME_W-1:0] = active_reg;
                rd_mux[sdp_pkg::STATUS_MODE_BIT] = mode_serial_reg;
            end
            sdp_pkg::SHIFT_ADDR: begin
                rd_mux[sdp_pkg::FRAME_W-1:0] = shift_reg;
            end
            default: begin
                rd_mux = '0;                    // Unmapped reads zero
            end
        endcase
    end

    // Capture answer in setup so data and error come from flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !addr_ok;
        end
    end

    // Every access completes in its first access cycle
    assign pready = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Dividers
    logic div_clear;                            // Dividers held in reset
    logic out_a_clk;                            // Output A divided clock
    logic out_b_clk;                            // Output B divided clock
    logic fb_clk;                               // Feedback divider output

    assign div_clear = ctrl_reg[sdp_pkg::CTRL_CLEAR_BIT];

    // Output A: select code through lookup to an even ratio
    sdp_out_div #(.HALF_W(sdp_pkg::HALF_W)) u_div_a (
        .mclk(mclk),
        .rst(rst),
        .clear(div_clear),
        .half(sdp_pkg::div_half(active_reg.first_out_div_sel)),
        .div_out(out_a_clk)
    );

    // Output B: same table, own select
    sdp_out_div #(.HALF_W(sdp_pkg::HALF_W)) u_div_b (
        .mclk(mclk),
        .rst(rst),
        .clear(div_clear),
        .half(sdp_pkg::div_half(active_reg.second_out_div_sel)),
        .div_out(out_b_clk)
    );

    // Feedback probe copy toggles every value cycles; lock range is the controller's job
    sdp_out_div #(.HALF_W(sdp_pkg::HALF_W)) u_div_fb (
        .mclk(mclk),
        .rst(rst),
        .clear(div_clear),
        .half(active_reg.fb_div),
        .div_out(fb_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Output pairs, probe and reference copy
    logic pair_a_on;                            // Pair A enabled and running
    logic pair_b_on;                            // Pair B enabled and running
    logic probe_next;                           // Probe level to register

    assign pair_a_on = ctrl_reg[sdp_pkg::CTRL_OE_A_BIT] && !div_clear;
    assign pair_b_on = ctrl_reg[sdp_pkg::CTRL_OE_B_BIT] && !div_clear;

    // Probe source; parallel mode always gives low
    always_comb begin
        probe_next = 1'b0;
        if (mode_serial_reg) begin
            case (sdp_pkg::sdp_probe_t'(active_reg.probe_sel))
                sdp_pkg::PROBE_LOW: probe_next = 1'b0;
                sdp_pkg::PROBE_SHIFT: probe_next = shift_reg[sdp_pkg::FRAME_W-1];
                sdp_pkg::PROBE_FB: probe_next = fb_clk;
                sdp_pkg::PROBE_OUT_A: probe_next = out_a_clk;
                default: probe_next = 1'b0;
            endcase
        end else begin
            probe_next = 1'b0;
        end
    end

    // Registered outputs: disabled or cleared pairs sit true low, comp high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            first_pair_true <= 1'b0;
            first_pair_comp <= 1'b1;
            second_pair_true <= 1'b0;
            second_pair_comp <= 1'b1;
            probe_out <= 1'b0;
        end else begin
            first_pair_true <= pair_a_on & out_a_clk;
            first_pair_comp <= ~(pair_a_on & out_a_clk);
            second_pair_true <= pair_b_on & out_b_clk;
            second_pair_comp <= ~(pair_b_on & out_b_clk);
            probe_out <= probe_next;
        end
    end

    // Reference copy; level is carried even while not driven
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_out <= 1'b0;
            ref_out_oe <= 1'b0;
        end else begin
            ref_out <= sync_b_reg[P_REF];
            ref_out_oe <= ctrl_reg[sdp_pkg::CTRL_OE_REF_BIT];
        end
    end

endmodule : sdp_program_port
`default_nettype wire

// file: test/sdp_program_port_assertions.sv
// Concurrent checks on the program port outputs
`timescale 1ns/100ps
`default_nettype none

module sdp_chk #(
    parameter int ADDR_W = 8                    // APB address width
) (
    input wire logic mclk,                      // System clock
    input wire logic rst,                       // Async reset, active high
    input wire logic psel,                      // APB select
    input wire logic penable,                   // APB access phase
    input wire logic pwrite,                    // APB direction
    input wire logic [ADDR_W-1:0] paddr,        // APB address
    input wire logic [31:0] pwdata,             // APB write data
    input wire logic [31:0] prdata,             // APB read data
    input wire logic pready,                    // APB ready
    input wire logic pslverr,                   // APB error
    input wire logic parallel_latch_strobe_n,   // Parallel strobe pin
    input wire logic first_pair_true,           // Pair A true
    input wire logic first_pair_comp,           // Pair A complement
    input wire logic second_pair_true,          // Pair B true
    input wire logic second_pair_comp,          // Pair B complement
    input wire logic probe_out,                 // Probe output
    input wire logic ref_out_oe                 // Reference drive enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [3:0] ctrl_sh;                        // Shadow of control register
    logic [2:0] settle;                         // Cycles since control write
    logic [2:0] par_cnt;                        // Cycles strobe held low
    logic unmapped;                             // Address outside the map
    assign unmapped = paddr != sdp_pkg::CTRL_ADDR && paddr != sdp_pkg::STATUS_ADDR
        && paddr != sdp_pkg::SHIFT_ADDR;
    ////////////////////////////////////////////////////////////////////////////////
    // Track control writes; settle saturates so gating has time to land
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_sh <= sdp_pkg::CTRL_RESET;
            settle <= 3'h0;
        end else if (psel && penable && pwrite && pready && paddr == sdp_pkg::CTRL_ADDR) begin
            ctrl_sh <= pwdata[3:0];
            settle <= 3'h0;
        end else if (settle != 3'h4) begin
            settle <= settle + 3'h1;
        end
    end
    // Count a long low strobe, pins are synchronised first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            par_cnt <= 3'h0;
        end else if (parallel_latch_strobe_n) begin
            par_cnt <= 3'h0;
        end else if (par_cnt != 3'h7) begin
            par_cnt <= par_cnt + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_high: assert property (pready) else $error("pready low");
    a_pair_a_comp: assert property (first_pair_comp == !first_pair_true) else $error("A pair");
    a_pair_b_comp: assert property (second_pair_comp == !second_pair_true) else $error("B pair");
    a_err_unmapped: assert property (psel && penable |-> pslverr == unmapped)
        else $error("pslverr wrong");
    a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved");
    a_ref_enable: assert property (settle == 3'h4 |-> ref_out_oe == ctrl_sh[2])
        else $error("ref enable");
    a_pair_a_gate: assert property (settle == 3'h4 && (!ctrl_sh[0] || ctrl_sh[3]) |->
        !first_pair_true) else $error("A not gated");
    a_pair_b_gate: assert property (settle == 3'h4 && (!ctrl_sh[1] || ctrl_sh[3]) |->
        !second_pair_true) else $error("B not gated");
    a_probe_parallel: assert property (par_cnt == 3'h7 |-> !probe_out)
        else $error("probe not low");
endmodule : sdp_chk

bind sdp_program_port sdp_chk #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .parallel_latch_strobe_n(parallel_latch_strobe_n),
    .first_pair_true(first_pair_true), .first_pair_comp(first_pair_comp),
    .second_pair_true(second_pair_true), .second_pair_comp(second_pair_comp),
    .probe_out(probe_out), .ref_out_oe(ref_out_oe));
`default_nettype wire

// file: test/sdp_cfg_model.sv
// Configuration controller model driving the serial pins
`timescale 1ns/100ps
`default_nettype none

module sdp_cfg_model (
    input wire logic mclk,                      // Bench clock
    output logic serial_clk,                    // Stands low outside frames
    output logic serial_data,                   // Pulled low when idle
    output logic serial_load                    // Load strobe
);
    initial {serial_clk, serial_data, serial_load} = 3'h0;
    // Each level lasts at least 4 cycles so the synchronisers see it
    task automatic gap;
        repeat (4) @(posedge mclk);
    endtask : gap
    task automatic set_load(input logic v);
        @(posedge mclk);
        serial_load <= v;
        gap();
    endtask : set_load
    // Frame goes out top bit first, data steady around the rise
    task automatic shift(input logic [16:0] f);
        for (int i = 16; i >= 0; i--) begin
            @(posedge mclk);
            serial_data <= f[i];
            gap();
            serial_clk <= 1'b1;
            gap();
            serial_clk <= 1'b0;
        end
        gap();
        serial_data <= 1'b0;
    endtask : shift
endmodule : sdp_cfg_model
`default_nettype wire

// file: test/synth_divider_program_port_tb.sv
// Self-checking bench for the divider program port
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module synth_divider_program_port_tb;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, strobe_n = 0, ref_in = 0;
    logic [7:0] paddr = 0;                      // APB address
    logic [31:0] pwdata = 0, prdata, rd, seed = 32'h2d, m[5];
    logic [8:0] fb_pins = 0;                    // Strap feedback pins
    logic [2:0] sel_a = 0, sel_b = 0;           // Strap select pins
    logic pready, pslverr, er, s_clk, s_dat, s_ld, pa_t, pa_c, pb_t, pb_c, probe, ref_out, ref_oe;
    logic [16:0] exp_set = 0, f;                // Model of the active setting
    logic exp_mode = 0;                         // Model of serial mode flag
    int err_count = 0, n_compared = 0, cyc = 0, rt[8] = '{2, 4, 6, 8, 10, 12, 16, 20};
    int np[4] = '{0, 0, 5, 120};                // Probe rises per 240 cycles
    sdp_program_port u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .parallel_latch_strobe_n(strobe_n), .fb_div_pins(fb_pins),
        .first_out_div_sel(sel_a), .second_out_div_sel(sel_b), .serial_clk(s_clk),
        .serial_data(s_dat), .serial_load(s_ld), .ref_in(ref_in), .first_pair_true(pa_t),
        .first_pair_comp(pa_c), .second_pair_true(pb_t), .second_pair_comp(pb_c),
        .probe_out(probe), .ref_out(ref_out), .ref_out_oe(ref_oe));
    sdp_cfg_model u_cfg (.mclk(mclk), .serial_clk(s_clk), .serial_data(s_dat), .serial_load(s_ld));
    ////////////////////////////////////////////////////////////////////////////////
    always #5 mclk = ~mclk;
    // Hang guard; the full run needs well under this
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            wrap_up();
        end
    end
    always @(posedge mclk) if (cyc % 3 == 0) ref_in <= !ref_in;
    function automatic logic [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk_st;
        apb(1'b0, sdp_pkg::STATUS_ADDR, 32'h0);
        `CHK(rd, {14'h0, exp_mode, exp_set})
    endtask : chk_st
    // Count highs of both pairs and probe, rises of pair A and probe, over n cycles; ends on a rising edge
    task automatic meas(input int n);
        logic a0, p0;
        m = '{default: 0};
        @(negedge mclk);
        a0 = pa_t;
        p0 = probe;
        repeat (n) begin
            @(negedge mclk);
            m[0] += pa_t;
            m[1] += pb_t;
            m[2] += pa_t && !a0;
            m[3] += probe && !p0;
            m[4] += probe;
            a0 = pa_t;
            p0 = probe;
        end
        @(posedge mclk);
    endtask : meas
    task automatic wrap_up;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        `CHK(ref_oe, 1'b0)
        apb(1'b0, sdp_pkg::CTRL_ADDR, 32'h0);
        `CHK(rd, 32'h3)
        apb(1'b1, sdp_pkg::STATUS_ADDR, 32'hffff_ffff);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK({er, rd}, 33'h1_0000_0000)
        // Every select code through the straps, duty and ratio
        for (int c = 0; c < 8; c++) begin
            fb_pins <= 9'd23 + 9'(rnd() % 8);
            sel_a <= 3'(c);
            sel_b <= 3'(7 - c);
            repeat (8) @(posedge mclk);
            exp_set = {exp_set[16:15], 3'(c), 3'(7 - c), fb_pins};
            chk_st();
            meas(240);
            `CHK(m[2], 240 / rt[c])
            `CHK(m[0] * 100 + m[1], 12120)
        end
        strobe_n <= 1'b1;
        repeat (6) @(posedge mclk);
        fb_pins <= ~fb_pins;
        sel_a <= 3'h2;
        repeat (8) @(posedge mclk);
        chk_st();
        // Shift, transfer, freeze, then transparent load
        f = {8'(rnd()), 9'd23 + 9'(rnd() % 8)};
        u_cfg.shift(f);
        apb(1'b0, sdp_pkg::SHIFT_ADDR, 32'h0);
        `CHK(rd, {15'h0, f})
        chk_st();
        u_cfg.set_load(1'b1);
        exp_set = f;
        exp_mode = 1'b1;
        chk_st();
        u_cfg.set_load(1'b0);
        u_cfg.shift({f[16:9], 9'd30});
        chk_st();
        u_cfg.set_load(1'b1);
        for (int p = 0; p < 4; p++) begin
            exp_set = {2'(p), 3'h0, 3'h1, 9'd24};
            u_cfg.shift(exp_set);
            chk_st();
            meas(240);
            `CHK(m[3], np[p])
        end
        u_cfg.set_load(1'b0);
        // Back to parallel: probe forced low, probe bits kept
        strobe_n <= 1'b0;
        repeat (8) @(posedge mclk);
        exp_set = {exp_set[16:15], sel_a, sel_b, fb_pins};
        exp_mode = 1'b0;
        chk_st();
        meas(40);
        `CHK(m[4], 0)
        apb(1'b1, sdp_pkg::CTRL_ADDR, 32'h2);
        meas(40);
        `CHK(m[0], 0)
        apb(1'b1, sdp_pkg::CTRL_ADDR, 32'hb);
        meas(40);
        `CHK(m[0] + m[1], 0)
        chk_st();
        apb(1'b1, sdp_pkg::CTRL_ADDR, 32'h7);
        repeat (6) @(negedge mclk);
        `CHK({ref_oe, ref_out}, {1'b1, !ref_in})
        wrap_up();
    end
endmodule : synth_divider_program_port_tb
`default_nettype wire
